// ==== shared/dsomc_pkg.sv ====
package dsomc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] REG_SSC_CTRL = 8'h08;
  localparam logic [7:0] REG_OUT_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_GPIO = 8'h0C;
  localparam logic [7:0] SSC_IDX = 8'h02;
  localparam logic [7:0] SSC_RESET = 8'h00;
  localparam int SSC_PROF_LSB = 0;
  localparam int SSC_PROF_W = 4;
  localparam logic OUT_EDGE_RESET = 1'b1;
  localparam logic REF_EXTOSC_RESET = 1'b1;
  localparam int OUT_EDGE_BIT = 0;
  localparam int OUT_REFSEL_BIT = 1;
  // ----------------------------------------
  // mode codes and strap decode
  // ----------------------------------------
  typedef enum logic [1:0] {MODE_12LF, MODE_12HF, MODE_10B} dsomc_mode_e;
  localparam logic [1:0] STRAP_0K = 2'h0;
  localparam logic [1:0] STRAP_3K = 2'h1;
  localparam logic [1:0] STRAP_11K = 2'h2;
  // link clock division per mode, in half steps: 2=1, 3=1.5, 4=2
  localparam logic [2:0] DIV_HALF_12LF = 3'h2;
  localparam logic [2:0] DIV_HALF_12HF = 3'h3;
  localparam logic [2:0] DIV_HALF_10B = 3'h4;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SSC_MIN_MHZ = 25;
  localparam int SSC_MAX_MHZ = 100;
  localparam int SYNC_GAP_CYC_10B = 10;
  localparam int LOCK_TIME_US = 2;
  localparam int LOCK_CYC = LOCK_TIME_US * CLK_MHZ;
  localparam int STAGGER_W = 3;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
endpackage : dsomc_pkg

// ==== src/dsomc_sync3.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// three flop pin synchroniser
// ----------------------------------------
module dsomc_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : dsomc_sync3

// ==== src/dsomc_top.sv ====
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module dsomc_top
  import dsomc_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int GPIO_N = 4,
  parameter int LOCK_CYCLES = LOCK_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins
  input wire logic chipEnableNPin,
  input wire logic [1:0] modeSelectResistor,
  input wire logic serialActive,
  // recovered parallel stream
  input wire logic [DATA_W-1:0] rxData,
  input wire logic rxHorizSync,
  input wire logic rxVertSync,
  // parallel outputs
  output logic [DATA_W-1:0] pixData,
  output logic horizSync,
  output logic vertSync,
  output logic pixClock,
  output logic pixOe,
  output logic lockOut,
  output logic lockOe,
  output logic [SSC_PROF_W-1:0] sscProfileOut,
  output logic [GPIO_N-1:0] desIoOut,
  output logic [GPIO_N-1:0] desIoOe,
  output logic [GPIO_N-1:0] desIoFwdEn,
  // back channel config
  output logic [1:0] bcMode,
  output logic [2:0] bcDivHalf,
  output logic bcValid
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] pinSync;
  logic enabled;
  logic [1:0] strapSync;
  logic linkActive;

  dsomc_sync3 #(.W(4)) u_sync (
    .clock(clock),
    .rst(rst),
    .din({serialActive, modeSelectResistor, chipEnableNPin}),
    .dout(pinSync)
  );
  assign enabled = pinSync[0];
  assign strapSync = pinSync[2:1];
  assign linkActive = pinSync[3];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] sscCtrl_r;
  logic edgeRise_r;
  logic refExtOsc_r;
  logic [GPIO_N-1:0] gpioVal_r;
  logic aphWr_r;
  logic aphRd_r;
  logic [7:0] aphAddr_r;
  logic aphTake;

  assign aphTake = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aphWr_r <= 1'b0;
      aphRd_r <= 1'b0;
      aphAddr_r <= 8'h00;
    end else begin
      aphWr_r <= aphTake && hwrite;
      aphRd_r <= aphTake && !hwrite;
      if (aphTake) begin
        aphAddr_r <= haddr;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sscCtrl_r <= SSC_RESET;
      edgeRise_r <= OUT_EDGE_RESET;
      refExtOsc_r <= REF_EXTOSC_RESET;
      gpioVal_r <= '0;
    end else if (aphWr_r) begin
      unique case (aphAddr_r)
        REG_SSC_CTRL: sscCtrl_r <= hwdata[7:0];
        REG_OUT_CTRL: begin
          edgeRise_r <= hwdata[OUT_EDGE_BIT];
          refExtOsc_r <= hwdata[OUT_REFSEL_BIT];
        end
        REG_GPIO: gpioVal_r <= hwdata[GPIO_N-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // mode strap and lock sequence
  // ----------------------------------------
  typedef enum logic [1:0] {ST_OFF, ST_STRAP, ST_LOCKING, ST_LOCKED} dsomc_state_e;
  dsomc_state_e state_r;
  dsomc_mode_e mode_r;
  logic [$clog2(LOCK_CYCLES+1)-1:0] lockCnt_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_OFF;
      mode_r <= MODE_12LF;
      lockCnt_r <= '0;
    end else if (!enabled) begin
      state_r <= ST_OFF;
      lockCnt_r <= '0;
    end else begin
      unique case (state_r)
        ST_OFF: state_r <= ST_STRAP;
        ST_STRAP: begin
          unique case (strapSync)
            STRAP_3K: mode_r <= MODE_12HF;
            STRAP_11K: mode_r <= MODE_10B;
            default: mode_r <= MODE_12LF;
          endcase
          state_r <= ST_LOCKING;
        end
        ST_LOCKING: begin
          if (!linkActive) begin
            lockCnt_r <= '0;
          end else if (lockCnt_r == ($clog2(LOCK_CYCLES+1))'(LOCK_CYCLES - 1)) begin
            state_r <= ST_LOCKED;
          end else begin
            lockCnt_r <= lockCnt_r + 1'b1;
          end
        end
        ST_LOCKED: begin
          if (!linkActive) begin
            state_r <= ST_LOCKING;
            lockCnt_r <= '0;
          end
        end
      endcase
    end
  end

  // back channel mode forwarding
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bcMode <= 2'h0;
      bcDivHalf <= DIV_HALF_12LF;
      bcValid <= 1'b0;
    end else begin
      bcValid <= (state_r == ST_LOCKING) || (state_r == ST_LOCKED);
      bcMode <= mode_r;
      unique case (mode_r)
        MODE_12HF: bcDivHalf <= DIV_HALF_12HF;
        MODE_10B: bcDivHalf <= DIV_HALF_10B;
        default: bcDivHalf <= DIV_HALF_12LF;
      endcase
    end
  end

  // ----------------------------------------
  // output strobe, stagger and spread
  // ----------------------------------------
  logic [15:0] lfsr_r;
  logic [STAGGER_W-1:0] stagCnt_r;
  logic [DATA_W-1:0] pend_r;
  logic pixPhase_r;
  logic strobe;
  logic locked;

  // power-down drops lock at once, with the output enables
  assign locked = (state_r == ST_LOCKED) && enabled;
  assign strobe = pixPhase_r == edgeRise_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lfsr_r <= LFSR_SEED;
      pixPhase_r <= 1'b0;
      stagCnt_r <= '0;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      pixPhase_r <= !pixPhase_r;
      stagCnt_r <= stagCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pixData <= '0;
      horizSync <= 1'b0;
      vertSync <= 1'b0;
      pend_r <= '0;
    end else if (!locked) begin
      pixData <= '0;
      horizSync <= 1'b0;
      vertSync <= 1'b0;
      pend_r <= '0;
    end else begin
      if (strobe) begin
        pend_r <= rxData ^ pixData;
        horizSync <= rxHorizSync;
        vertSync <= rxVertSync;
      end else begin
        // random lane release within the strobe window
        for (int i = 0; i < DATA_W; i++) begin
          // last two slots force release, so either strobe phase drains
          if (pend_r[i] && (lfsr_r[i % 16] || stagCnt_r[STAGGER_W-1:1] == '1)) begin
            pixData[i] <= !pixData[i];
            pend_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pixClock <= 1'b0;
      sscProfileOut <= '0;
    end else begin
      pixClock <= locked && pixPhase_r;
      // spread profile applied while locked across the supported range
      sscProfileOut <= locked ? sscCtrl_r[SSC_PROF_LSB +: SSC_PROF_W] : '0;
    end
  end

  // ----------------------------------------
  // output enables and general-purpose pins
  // ----------------------------------------
  always_comb begin
    pixOe = enabled;
    lockOe = enabled;
    lockOut = locked;
    for (int i = 0; i < GPIO_N; i++) begin
      // oscillator mode keeps pins two and three local
      desIoFwdEn[i] = enabled && !(refExtOsc_r && (i == 2 || i == 3));
      desIoOe[i] = enabled;
      desIoOut[i] = gpioVal_r[i];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (aphTake && !hwrite) begin
      unique case (haddr)
        REG_SSC_CTRL: hrdata <= {24'h000000, sscCtrl_r};
        REG_OUT_CTRL: hrdata <= {30'h0, refExtOsc_r, edgeRise_r};
        REG_STATUS: hrdata <= {26'h0, mode_r, state_r, locked, enabled};
        REG_GPIO: hrdata <= {{(32-GPIO_N){1'b0}}, gpioVal_r};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : dsomc_top

// ==== tb/dsomc_chk.sv ====
`timescale 1ns/10ps
module dsomc_chk
  import dsomc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched ports
  input wire logic chipEnableNPin,
  input wire logic serialActive,
  input wire logic [11:0] pixData,
  input wire logic pixClock,
  input wire logic pixOe,
  input wire logic lockOut,
  input wire logic lockOe,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [1:0] bcMode,
  input wire logic [2:0] bcDivHalf,
  input wire logic bcValid
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_oe_pd_off: assert property (!chipEnableNPin [*5] |-> !pixOe && !lockOe)
    else $error("outputs driven in power down");
  a_lock_oe_on: assert property (lockOut |-> pixOe && lockOe)
    else $error("lock without driven outputs");
  a_lock_after_seq: assert property ($rose(lockOut) |-> $past(serialActive, 4))
    else $error("lock without serial stream");
  a_data_unlocked: assert property (!lockOut && !$past(lockOut) |-> pixData == 0 && !pixClock)
    else $error("outputs active while unlocked");
  a_clk_runs: assert property (lockOut && $past(lockOut, 2) |-> pixClock != $past(pixClock))
    else $error("pixel clock stalled");
  a_div_match: assert property (bcValid |-> bcMode != 2'h3 && bcDivHalf == 3'(bcMode) + 3'h2)
    else $error("division does not match mode");
  a_mode_hold: assert property (lockOut && $past(lockOut) |-> $stable(bcMode))
    else $error("mode changed while locked");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
  c_lock: cover property ($rose(lockOut));
  c_ten_bit: cover property (bcValid && bcMode == 2'h2);
  c_power_down: cover property ($fell(pixOe));
endmodule : dsomc_chk

// ==== tb/dsomc_ser_model.sv ====
`timescale 1ns/10ps
module dsomc_ser_model
  import dsomc_pkg::*;
(
  // control
  input wire logic clock,
  input wire logic linkOn,
  input wire logic [11:0] word,
  input wire logic [1:0] mode,
  input wire logic [3:0] fwdEn,
  input wire logic [3:0] desIo,
  // stream
  output logic serialActive,
  output logic [11:0] rxData,
  output logic rxHorizSync,
  output logic rxVertSync,
  output logic [3:0] serOut
);
  logic [3:0] gap = 4'h0;
  initial begin
    serialActive = 1'b0;
    rxData = 12'h000;
    rxHorizSync = 1'b0;
    rxVertSync = 1'b0;
  end
  // released link shows inverted stale data
  always @(posedge clock) begin
    serialActive <= linkOn;
    rxData <= linkOn ? word : ~rxData;
    gap <= (gap == 4'h9) ? 4'h0 : gap + 4'h1;
    if (gap == 4'h9 || (mode != 2'h2 && gap[0])) begin
      rxHorizSync <= ~rxHorizSync;
      rxVertSync <= rxHorizSync;
    end
  end
  // oscillator advance per pixel in sixths of its period
  int oscAcc = 0;
  int oscStep;
  logic oscHalf = 1'b0;
  assign oscStep = (mode == 2'h2) ? 3 : ((mode == 2'h1) ? 4 : 6);
  always @(posedge clock) begin
    if (oscAcc + oscStep >= 6) begin
      oscAcc <= oscAcc + oscStep - 6;
      oscHalf <= ~oscHalf;
    end else begin
      oscAcc <= oscAcc + oscStep;
    end
  end
  // when not forwarded, pin two carries the oscillator half rate and pin three is held low
  always_comb begin
    serOut = desIo & fwdEn;
    if (!fwdEn[2]) serOut[2] = oscHalf;
    if (!fwdEn[3]) serOut[3] = 1'b0;
  end
endmodule : dsomc_ser_model

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import dsomc_pkg::*;
  logic clock, rst, hsel, hwrite, hreadyout, hresp, chipEnableNPin, serialActive, linkOn;
  logic [7:0] haddr;
  logic [1:0] htrans, modeSelectResistor, bcMode;
  logic [2:0] hsize, bcDivHalf;
  logic [3:0] sscProfileOut, serOut;
  logic [31:0] hwdata, hrdata, q, v, g;
  logic [11:0] rxData, pixData, word;
  logic rxHorizSync, rxVertSync, horizSync, vertSync, pixClock, pixOe, lockOut, lockOe, bcValid;
  logic [3:0] desIoOut, desIoOe, desIoFwdEn;
  int badCount = 0;
  int testsRun = 0;
  int cyc = 0;
  int mdl[4];
  integer seed = 32'hA8C31DFD;
  dsomc_top #(.LOCK_CYCLES(8)) dut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .chipEnableNPin,
    .modeSelectResistor, .serialActive, .rxData, .rxHorizSync, .rxVertSync, .pixData,
    .horizSync, .vertSync, .pixClock, .pixOe, .lockOut, .lockOe, .sscProfileOut, .desIoOut,
    .desIoOe, .desIoFwdEn, .bcMode, .bcDivHalf, .bcValid);
  dsomc_ser_model ser (.clock, .linkOn, .word, .mode(bcMode), .fwdEn(desIoFwdEn),
    .desIo(desIoOut), .serialActive, .rxData, .rxHorizSync, .rxVertSync, .serOut);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      badCount++;
      endOfTest();
    end
  end
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clock);
    while (!hreadyout) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (!hreadyout) @(posedge clock);
    q = hrdata;
    if (w && a < 8'h10 && a != REG_STATUS) mdl[a[3:2]] = d;
  endtask : ahb
  task up(input int m);
    chipEnableNPin <= 1'b0;
    repeat (6) @(posedge clock);
    chk("oe", {pixOe, lockOe, desIoOe}, 32'h0);
    modeSelectResistor <= m[1:0];
    chipEnableNPin <= 1'b1;
    for (int i = 0; i < 100 && !lockOut; i++) @(posedge clock);
  endtask : up
  task endOfTest();
    $display("comparisons %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : endOfTest
  initial begin
    rst = 1'b1;
    hsel = 1'b1;
    hwrite = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    chipEnableNPin = 1'b0;
    modeSelectResistor = 2'h0;
    linkOn = 1'b1;
    word = 12'h000;
    mdl = '{3, 0, 0, 0};
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, 8'(4 * i), 32'h0);
      if (i != 1) chk("reset value", q, 32'(mdl[i]));
    end
    ahb(1'b1, 8'h10, 32'hFFFFFFFF);
    ahb(1'b0, 8'h10, 32'h0);
    chk("unmapped", q, 32'h0);
    for (int m = 0; m < 3; m++) begin
      up(m);
      chk("lock", lockOut, 32'h1);
      chk("mode", {bcValid, bcMode}, 32'(4 + m));
      chk("division", bcDivHalf, 32'(m + 2));
      ahb(1'b0, REG_STATUS, 32'h0);
      chk("status mode", q[5:4], 32'(m));
      modeSelectResistor <= 2'((m + 1) % 3);
      v = 32'($random(seed)) & 32'hF;
      ahb(1'b1, REG_SSC_CTRL, v);
      ahb(1'b0, REG_SSC_CTRL, 32'h0);
      chk("spread reg", q, 32'(mdl[2]));
      chk("spread out", sscProfileOut, v[3:0]);
      chk("mode hold", bcMode, 32'(m));
      g = 32'($random(seed)) & 32'hF;
      ahb(1'b1, REG_GPIO, g);
      @(posedge clock);
      chk("gpio out", desIoOut, g);
      for (int e = 0; e < 2; e++) begin
        ahb(1'b1, REG_OUT_CTRL, {30'h0, m[0], e[0]});
        @(posedge clock);
        chk("forward", desIoFwdEn[3:2], m[0] ? 32'h0 : 32'h3);
        chk("ser pins low", serOut[1:0], g[1:0]);
        chk("ser pin three", serOut[3], m[0] ? 32'h0 : 32'(g[3]));
        word <= 12'($random(seed));
        repeat (14) @(posedge clock);
        chk("pixel data", pixData, word);
      end
    end
    linkOn <= 1'b0;
    repeat (10) @(posedge clock);
    chk("lock loss", lockOut, 32'h0);
    chk("idle outputs", {vertSync, horizSync, pixData}, 32'h0);
    chipEnableNPin <= 1'b0;
    repeat (6) @(posedge clock);
    chk("oe off", {pixOe, lockOe, desIoOe}, 32'h0);
    endOfTest();
  end
endmodule : testbench
bind dsomc_top dsomc_chk chk_i (.clock, .rst, .chipEnableNPin, .serialActive, .pixData,
  .pixClock, .pixOe, .lockOut, .lockOe, .hreadyout, .hresp, .bcMode, .bcDivHalf, .bcValid);
